// ===== hw/ucb_char_baud_timeout.v
// Character holding, baud divisor, receive time-out and interrupt mask block
//
// Function
// - One mask bit per serial event; 1 passes the interrupt, 0 blocks it.
// - Pin-change mask bits change only via enable or disable register writes.
// - LIN event enable bits: writing 1 enables, writing 0 does nothing.
// - Read-only receive holding register at 0x080 shows last 9-bit character.
// - Characters narrower than 9 bits sit right aligned at bit 0.
// - Normal read of receive holding register clears receive-ready flag.
// - Shadow read path returns the character without clearing receive-ready.
// - Write at 0x084 queues one character of up to 9 bits.
// - Async bit rate equals clock over sixteen times divisor.
// - Sync internal-clock bit rate equals clock over divisor.
// - Sync external-clock mode ignores the divisor completely.
// - Time-out value 0 disables the receive time-out.
// - Counter reloads on start-time-out command and each received character after the first.
// - Time-out lasts value bit periods async, four times that in sync.
// - Receiver disable freezes the counter; enable resumes without reload.
// - Time-out flag sets on expiry after start command; clear while value zero.
// - Overrun sets when a character arrives while receive-ready is set.
`timescale 1ns/100ps
`include "ucb_defines.vh"
module ucb_char_baud_timeout
(
  input  wire        clk_sys,
  input  wire        arst_n,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        rxCharStrobe,
  input  wire [8:0]  rxCharIn,
  input  wire [17:0] extEvents,
  input  wire        txTake,
  input  wire        extClkPin,
  output reg  [8:0]  txCharOut,
  output reg         txCharValid,
  output reg         rxEnabled,
  output reg         bitTick,
  output reg         sampleTick,
  output reg         irqOut
);
  // ************************************
  // Registers
  // ************************************
  reg  [30:0] irqMask_r;
  reg  [8:0]  rxChar_r;
  reg  [8:0]  txChar_r;
  reg  [15:0] baudDiv_r;
  reg  [15:0] silenceLimit_r;
  reg  [15:0] toCnt_r;
  reg  [1:0]  toSub_r;
  reg         toArmed_r;
  reg         rxStarted_r;
  reg         rxAvail_r;
  reg         txSlotFree_r;
  reg         overrun_r;
  reg         timeout_r;
  reg         syncMode_r;
  reg         extClock_r;
  reg         rx_enable_cmd_r;
  reg  [2:0]  extSync_r;
  reg         extTick_r;
  reg         dPend_r;
  reg         dWrite_r;
  reg  [7:0]  dAddr_r;
  wire        bitTickInt;
  wire        sampleTickInt;
  wire [30:0] statusVec;
  wire        wrEn;
  wire        rdEn;
  wire        toLoad;
  wire        toStep;

  // ************************************
  // Bus slave
  // ************************************
  // Zero wait state slave, always OKAY
  assign wrEn = dPend_r && dWrite_r;
  assign rdEn = dPend_r && !dWrite_r;

  function isOfs;
    input [7:0] a;
    input [7:0] ofs;
    begin
      isOfs = (a == ofs);
    end
  endfunction

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dPend_r   <= 1'b0;
      dWrite_r  <= 1'b0;
      dAddr_r   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      dPend_r   <= hsel && hready && htrans[1];
      dWrite_r  <= hwrite;
      dAddr_r   <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Event vector in mask-register bit order
  assign statusVec = {extEvents[17:11], 5'h00, extEvents[10:8], 4'h0, 1'b0,
                      extEvents[7:6], timeout_r, extEvents[5:4], overrun_r,
                      extEvents[3:2], 1'b0, txSlotFree_r, rxAvail_r};

  // Read data is combinational off the registered address-phase address so it stands in the data phase
  always @*
  begin
    hrdata = 32'h0000_0000;
    if (rdEn)
    begin
      if (isOfs(dAddr_r, `UCB_OFS_IRQ_MASK))
        hrdata = {1'b0, irqMask_r};
      else if (isOfs(dAddr_r, `UCB_OFS_RX_CHAR) || isOfs(dAddr_r, `UCB_OFS_RX_SHADOW))
        hrdata = {23'h000000, rxChar_r};
      else if (isOfs(dAddr_r, `UCB_OFS_BAUD_DIV))
        hrdata = {16'h0000, baudDiv_r};
      else if (isOfs(dAddr_r, `UCB_OFS_SILENCE))
        hrdata = {16'h0000, silenceLimit_r};
      else if (isOfs(dAddr_r, `UCB_OFS_STATUS))
        hrdata = {1'b0, statusVec};
      else if (isOfs(dAddr_r, `UCB_OFS_MODE))
        hrdata = {30'h0000_0000, extClock_r, syncMode_r};
    end
  end

  // ************************************
  // Mask, config and character registers
  // ************************************
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irqMask_r      <= `UCB_MASK_RST;
      baudDiv_r      <= `UCB_DIV_RST;
      silenceLimit_r <= `UCB_TO_RST;
      syncMode_r     <= 1'b0;
      extClock_r     <= 1'b0;
      txChar_r       <= 9'h000;
      txSlotFree_r   <= 1'b1;
      rxChar_r       <= 9'h000;
      rxAvail_r      <= 1'b0;
      overrun_r      <= 1'b0;
      rx_enable_cmd_r         <= 1'b0;
    end
    else
    begin
      // Set from enable, clear from disable; writing 0 is a no-op
      if (wrEn && isOfs(dAddr_r, `UCB_OFS_IRQ_ENABLE))
        irqMask_r <= irqMask_r | (hwdata[30:0] & `UCB_MASK_USED);
      else if (wrEn && isOfs(dAddr_r, `UCB_OFS_IRQ_DISABLE))
        irqMask_r <= irqMask_r & ~hwdata[30:0];
      if (wrEn && isOfs(dAddr_r, `UCB_OFS_BAUD_DIV))
        baudDiv_r <= hwdata[15:0];
      if (wrEn && isOfs(dAddr_r, `UCB_OFS_SILENCE))
        silenceLimit_r <= hwdata[15:0];
      if (wrEn && isOfs(dAddr_r, `UCB_OFS_MODE))
      begin
        syncMode_r <= hwdata[0];
        extClock_r <= hwdata[1];
      end
      // Writes while the slot is full are dropped; no back-pressure on the bus
      if (wrEn && isOfs(dAddr_r, `UCB_OFS_TX_CHAR) && txSlotFree_r)
      begin
        txChar_r     <= hwdata[8:0];
        txSlotFree_r <= 1'b0;
      end
      else if (txTake)
        txSlotFree_r <= 1'b1;
      if (wrEn && isOfs(dAddr_r, `UCB_OFS_COMMAND) && hwdata[`UCB_CMD_RX_DISABLE_CMD])
        rx_enable_cmd_r <= 1'b0;
      else if (wrEn && isOfs(dAddr_r, `UCB_OFS_COMMAND) && hwdata[`UCB_CMD_RX_ENABLE_CMD])
        rx_enable_cmd_r <= 1'b1;
      // New character wins over a same-cycle read clear
      if (rxCharStrobe)
      begin
        rxChar_r  <= rxCharIn;
        rxAvail_r <= 1'b1;
      end
      else if (rdEn && isOfs(dAddr_r, `UCB_OFS_RX_CHAR))
        rxAvail_r <= 1'b0;
      if (rxCharStrobe && rxAvail_r)
        overrun_r <= 1'b1;
      else if (wrEn && isOfs(dAddr_r, `UCB_OFS_COMMAND) && hwdata[`UCB_CMD_RSTSTA])
        overrun_r <= 1'b0;
    end
  end

  // ************************************
  // External clock sampling
  // ************************************
  // Three stages; a rising edge counts when stage two is high and stage three is still low
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      extSync_r <= 3'h0;
      extTick_r <= 1'b0;
    end
    else
    begin
      extSync_r <= {extSync_r[1:0], extClkPin};
      extTick_r <= extSync_r[1] && !extSync_r[2];
    end
  end

  ucb_baud_gen uBaud
  (
    .clk_sys      (clk_sys),
    .arst_n       (arst_n),
    .baudDivisor  (baudDiv_r),
    .syncMode     (syncMode_r),
    .extClock     (extClock_r),
    .extTick      (extTick_r),
    .sampleTick_r (sampleTickInt),
    .bitTick_r    (bitTickInt)
  );

  // ************************************
  // Receive time-out
  // ************************************
  // Reload on start command or on each character once started
  assign toLoad = (wrEn && isOfs(dAddr_r, `UCB_OFS_COMMAND) && hwdata[`UCB_CMD_STTTO]) ||
                  (rxCharStrobe && rxStarted_r);
  // Sync mode counts one step per four bit periods
  assign toStep = bitTickInt && rx_enable_cmd_r &&
                  (!syncMode_r || toSub_r == `UCB_SYNC_TO_BITS - 3'h1);

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      toCnt_r     <= 16'h0000;
      toSub_r     <= 2'h0;
      toArmed_r   <= 1'b0;
      rxStarted_r <= 1'b0;
      timeout_r   <= 1'b0;
    end
    else
    begin
      if (rxCharStrobe)
        rxStarted_r <= 1'b1;
      if (silenceLimit_r == 16'h0000)
      begin
        toArmed_r <= 1'b0;
        timeout_r <= 1'b0;
      end
      else if (toLoad)
      begin
        toCnt_r   <= silenceLimit_r;
        toSub_r   <= 2'h0;
        toArmed_r <= 1'b1;
        // Start command clears a pending flag unless a character reload comes in the same cycle; a character reload leaves it
        if (!(rxCharStrobe && rxStarted_r))
          timeout_r <= 1'b0;
      end
      else if (toArmed_r && bitTickInt && rx_enable_cmd_r)
      begin
        toSub_r <= toSub_r + 2'h1;
        if (toStep)
        begin
          toSub_r <= 2'h0;
          if (toCnt_r == 16'h0001)
          begin
            toArmed_r <= 1'b0;
            timeout_r <= 1'b1;
          end
          toCnt_r <= toCnt_r - 16'h0001;
        end
      end
    end
  end

  // ************************************
  // Outputs
  // ************************************
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      txCharOut   <= 9'h000;
      txCharValid <= 1'b0;
      rxEnabled   <= 1'b0;
      bitTick     <= 1'b0;
      sampleTick  <= 1'b0;
      irqOut      <= 1'b0;
    end
    else
    begin
      txCharOut   <= txChar_r;
      txCharValid <= !txSlotFree_r;
      rxEnabled   <= rx_enable_cmd_r;
      bitTick     <= bitTickInt;
      sampleTick  <= sampleTickInt;
      irqOut      <= |(statusVec & irqMask_r);
    end
  end
endmodule

// ===== hw/ucb_defines.vh
// Register map, field layout and timing constants of the character/baud/time-out block
`ifndef UCB_DEFINES_VH
`define UCB_DEFINES_VH
`define UCB_OFS_IRQ_ENABLE   8'h74
`define UCB_OFS_IRQ_DISABLE  8'h78
`define UCB_OFS_IRQ_MASK     8'h7c
`define UCB_OFS_RX_CHAR      8'h80
`define UCB_OFS_TX_CHAR      8'h84
`define UCB_OFS_BAUD_DIV     8'h88
`define UCB_OFS_SILENCE      8'h8c
`define UCB_OFS_RX_SHADOW    8'hc0
`define UCB_OFS_STATUS       8'hc4
`define UCB_OFS_COMMAND      8'hc8
`define UCB_OFS_MODE         8'hcc
`define UCB_CHAR_W           9
`define UCB_MASK_W           31
`define UCB_MASK_RST         31'h0000_0000
`define UCB_MASK_USED        31'h7f07_07ff
`define UCB_DIV_RST          16'h0000
`define UCB_TO_RST           16'h0000
`define UCB_OVERSAMPLE       5'h10
`define UCB_SYNC_TO_BITS     3'h4
`define UCB_BIT_RX_CHAR_AVAIL        0
`define UCB_BIT_TX_SLOT_FREE        1
`define UCB_BIT_OVRE         5
`define UCB_BIT_TIMEOUT      8
`define UCB_CMD_RSTSTA       8
`define UCB_CMD_RX_ENABLE_CMD         4
`define UCB_CMD_RX_DISABLE_CMD        5
`define UCB_CMD_STTTO        11
`endif

// ===== hw/ucb_baud_gen.v
// Baud divider: produces one-cycle bit and sample ticks from the divisor
`timescale 1ns/100ps
`include "ucb_defines.vh"
module ucb_baud_gen
(
  input  wire        clk_sys,
  input  wire        arst_n,
  input  wire [15:0] baudDivisor,
  input  wire        syncMode,
  input  wire        extClock,
  input  wire        extTick,
  output reg         sampleTick_r,
  output reg         bitTick_r
);
  reg  [15:0] divCnt_r;
  reg  [3:0]  overCnt_r;
  wire        divEdge;
  wire        sampleTick_nxt;
  wire        bitTick_nxt;

  // ************************************
  // Divider
  // ************************************
  // Divisor 0 never ticks, 1 ticks every cycle
  assign divEdge = (baudDivisor == 16'h0001) ||
                   ((baudDivisor > 16'h0001) && (divCnt_r >= baudDivisor - 16'h0001));
  // External sync clock bypasses the divisor
  assign sampleTick_nxt = (syncMode && extClock) ? extTick : divEdge;
  // Async: bit = 16 samples sync: bit = sample tick
  assign bitTick_nxt = syncMode ? sampleTick_nxt :
                       (sampleTick_nxt && overCnt_r == 4'hf);

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      divCnt_r     <= 16'h0000;
      overCnt_r    <= 4'h0;
      sampleTick_r <= 1'b0;
      bitTick_r    <= 1'b0;
    end
    else
    begin
      divCnt_r     <= (divEdge || baudDivisor < 16'h0002) ? 16'h0000 : divCnt_r + 16'h0001;
      if (sampleTick_nxt)
        overCnt_r <= overCnt_r + 4'h1;
      sampleTick_r <= sampleTick_nxt;
      bitTick_r    <= bitTick_nxt;
    end
  end
endmodule

// ===== verification/ucb_checker.sv
// Port checker for the character/baud/time-out block
`timescale 1ns/100ps
module ucb_checker
(
  input wire        clk_sys,
  input wire        arst_n,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        rxCharStrobe,
  input wire [8:0]  rxCharIn,
  input wire        txTake,
  input wire [8:0]  txCharOut,
  input wire        txCharValid,
  input wire        rxEnabled
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  reg       wrPh_r;
  reg       rdPh_r;
  reg [7:0] adr_r;
  reg [8:0] lastRx_r;
  // Data phase trackers, one cycle behind the address phase
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wrPh_r   <= 1'b0;
      rdPh_r   <= 1'b0;
      adr_r    <= 8'h00;
      lastRx_r <= 9'h000;
    end
    else
    begin
      wrPh_r <= hsel && hready && htrans[1] && hwrite;
      rdPh_r <= hsel && hready && htrans[1] && !hwrite;
      adr_r  <= haddr[7:0];
      if (rxCharStrobe)
        lastRx_r <= rxCharIn;
    end
  end
  wire txWr  = wrPh_r && adr_r == 8'h84;
  wire cmdWr = wrPh_r && adr_r == 8'hc8;
  property p_rxRead;
    rdPh_r && adr_r == 8'h80 |-> hrdata == {23'h0, lastRx_r};
  endproperty
  a_rxRead: assert property (p_rxRead) else $error("rx read wrong");
  property p_shadow;
    rdPh_r && adr_r == 8'hc0 |-> hrdata == {23'h0, lastRx_r};
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow read wrong");
  property p_txQueue;
    txWr && !txCharValid |-> ##2 txCharValid && txCharOut == $past(hwdata[8:0], 2);
  endproperty
  a_txQueue: assert property (p_txQueue) else $error("tx not queued");
  property p_txDrop;
    txWr && txCharValid && !txTake && !$past(txTake) |=> txCharValid && $stable(txCharOut);
  endproperty
  a_txDrop: assert property (p_txDrop) else $error("full slot overwritten");
  property p_txFree;
    txTake && txCharValid && !txWr |-> ##2 !txCharValid;
  endproperty
  a_txFree: assert property (p_txFree) else $error("slot not freed");
  property p_txRise;
    $rose(txCharValid) |-> $past(txWr, 2);
  endproperty
  a_txRise: assert property (p_txRise) else $error("slot filled alone");
  property p_rxOn;
    cmdWr && hwdata[4] && !hwdata[5] |-> ##2 rxEnabled;
  endproperty
  a_rxOn: assert property (p_rxOn) else $error("rx not enabled");
  property p_rxOff;
    cmdWr && hwdata[5] |-> ##2 !rxEnabled;
  endproperty
  a_rxOff: assert property (p_rxOff) else $error("rx not disabled");
  property p_rxKeep;
    !$stable(rxEnabled) |-> $past(cmdWr, 2);
  endproperty
  a_rxKeep: assert property (p_rxKeep) else $error("rx enable moved alone");
  c_full: cover property (txWr && txCharValid);
  c_take: cover property (txTake);
  c_wide: cover property (rdPh_r && adr_r == 8'h80 && hrdata[8]);
endmodule
bind ucb_char_baud_timeout ucb_checker u_ucb_checker (.clk_sys, .arst_n, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .rxCharStrobe, .rxCharIn, .txTake,
  .txCharOut, .txCharValid, .rxEnabled);

// ===== verification/ucb_serial_node.sv
// Remote serial node model: feeds received characters, takes queued ones
`timescale 1ns/100ps
module ucb_serial_node
(
  input  wire       clk_sys,
  input  wire [8:0] txCharOut,
  input  wire       txCharValid,
  output reg        rxCharStrobe,
  output reg  [8:0] rxCharIn,
  output reg        txTake
);
  int       takeDelay = 2;
  reg [8:0] lastTx_r  = 9'h000;
  initial
  begin
    rxCharStrobe = 1'b0;
    rxCharIn     = 9'h000;
    txTake       = 1'b0;
  end
  task sendChar(input [8:0] c);
    begin
      @(posedge clk_sys);
      rxCharStrobe <= 1'b1;
      rxCharIn     <= c;
      @(posedge clk_sys);
      rxCharStrobe <= 1'b0;
      rxCharIn     <= ~c; // Stale data inverted so an old value never passes
    end
  endtask
  // Slow transmitter: one-cycle take, then waits out the valid flag's lag
  always @(posedge clk_sys)
  begin
    if (txCharValid === 1'b1)
    begin
      repeat (takeDelay) @(posedge clk_sys);
      lastTx_r <= txCharOut;
      txTake   <= 1'b1;
      @(posedge clk_sys);
      txTake   <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  end
endmodule

// ===== verification/ucb_char_baud_timeout_tb.sv
// Self-checking bench for the character/baud/time-out block
`timescale 1ns/100ps
module ucb_char_baud_timeout_tb;
  reg         clk_sys = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  reg         extClk  = 1'b0, extRun = 1'b0;
  reg  [31:0] haddr   = 32'h0, hwdata = 32'h0, q;
  reg  [1:0]  htrans  = 2'h0;
  reg  [17:0] extEvents = 18'h0;
  wire [31:0] hrdata;
  wire [8:0]  rxCharIn, txCharOut;
  wire        hreadyout, hresp, rxCharStrobe, txTake, txCharValid, rxEnabled;
  wire        bitTick, sampleTick, irqOut;
  int         fails = 0;
  int         n_tests = 0;
  always #5 clk_sys = ~clk_sys;
  always #47 if (extRun) extClk = ~extClk;
  ucb_char_baud_timeout u_ucb_char_baud_timeout (.clk_sys, .arst_n, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .rxCharStrobe, .rxCharIn, .extEvents, .txTake, .extClkPin(extClk),
    .txCharOut, .txCharValid, .rxEnabled, .bitTick, .sampleTick, .irqOut);
  ucb_serial_node u_ucb_serial_node (.clk_sys, .txCharOut, .txCharValid,
    .rxCharStrobe, .rxCharIn, .txTake);
  // ****************************************
  // Bus and comparison tasks
  // ****************************************
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      n_tests++;
      if (got !== exp)
      begin
        fails++;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task waitRdy;
    int i;
    begin
      i = 0;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1)
      begin
        i++;
        if (i > 50)
        begin
          fails++;
          end_of_test;
        end
        @(posedge clk_sys);
      end
    end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h0, a};
      waitRdy;
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitRdy;
      q = hrdata;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] exp);
    begin
      xfer(1'b0, a, 32'h0);
      cmp(q, exp);
    end
  endtask
  task stb(input int idx, input bit exp);
    begin
      xfer(1'b0, 8'hc4, 32'h0);
      cmp(q[idx], exp);
    end
  endtask
  task ticks(input int n);
    begin
      q = 0;
      repeat (n)
      begin
        @(posedge clk_sys);
        if (bitTick === 1'b1)
          q++;
      end
    end
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rdc(8'h88, 32'h0);
    rdc(8'h8c, 32'h0);
    ticks(200); cmp(q, 0);
    cmp(hresp, 0); cmp(hreadyout, 1);
    xfer(1, 8'h88, 32'h2); ticks(330); cmp(q, 10);
    xfer(1, 8'hcc, 32'h1); xfer(1, 8'h88, 32'h4); ticks(40); cmp(q, 10);
    extRun = 1'b1;
    xfer(1, 8'hcc, 32'h3); xfer(1, 8'h88, 32'h0); ticks(200); cmp(q != 0, 1);
    extRun = 1'b0;
    xfer(1, 8'hcc, 32'h0); xfer(1, 8'h88, 32'h2);
    xfer(1, 8'h74, 32'hffff_ffff); rdc(8'h7c, `UCB_MASK_USED);
    xfer(1, 8'h74, 32'h0); rdc(8'h7c, `UCB_MASK_USED);
    xfer(1, 8'h78, 32'h7_0000); rdc(8'h7c, 32'h7f00_07ff);
    xfer(1, 8'h78, 32'hffff_ffff); rdc(8'h7c, 32'h0);
    extEvents <= 18'h4;
    xfer(1, 8'h74, 32'h8); repeat (3) @(posedge clk_sys); cmp(irqOut, 1);
    xfer(1, 8'h78, 32'h8); repeat (3) @(posedge clk_sys); cmp(irqOut, 0);
    extEvents <= 18'h0;
    u_ucb_serial_node.sendChar(9'h1a5);
    rdc(8'hc0, 32'h1a5); stb(0, 1);
    rdc(8'h80, 32'h1a5); stb(0, 0);
    u_ucb_serial_node.sendChar(9'h033);
    u_ucb_serial_node.sendChar(9'h0c3); stb(5, 1);
    rdc(8'h80, 32'h0c3);
    xfer(1, 8'hc8, 32'h100); stb(5, 0);
    u_ucb_serial_node.takeDelay = 30;
    xfer(1, 8'h84, 32'h1ab); xfer(1, 8'h84, 32'h055); cmp(txCharOut, 9'h1ab);
    repeat (40) @(posedge clk_sys);
    cmp(txCharValid, 0); cmp(u_ucb_serial_node.lastTx_r, 9'h1ab);
    xfer(1, 8'h8c, 32'h3); xfer(1, 8'hc8, 32'h10); xfer(1, 8'hc8, 32'h800);
    repeat (50) @(posedge clk_sys);
    xfer(1, 8'hc8, 32'h20); repeat (200) @(posedge clk_sys); stb(8, 0);
    xfer(1, 8'hc8, 32'h10); repeat (100) @(posedge clk_sys); stb(8, 1);
    xfer(1, 8'hc8, 32'h800); repeat (50) @(posedge clk_sys); stb(8, 0);
    xfer(1, 8'h8c, 32'h0); stb(8, 0);
    end_of_test;
  end
endmodule
